// ==== design/tbr_map.vh ====
// What this block does
// RULE_01: thirty-six track outputs, data on 2 to 33
// RULE_02: system outputs 0,1,34,35 never rotate
// RULE_03: data outputs split into groups of 8 or 16
// RULE_04: step advances per frame, restarts at even second
// RULE_05: rotation off unless track count divisible by eight
// RULE_06: eight-step when /8 only, or /16 at <=2 Mbit/s
// RULE_07: eight-step moves stream two tracks up, wrapping
// RULE_08: sixteen-step when /16 at >=4 Mbit/s
// RULE_09: sixteen-step even tracks: steps 8-15 cross halves
// RULE_10: odd tracks follow the even sixteen-step map
// RULE_11: parity over 8 or 16 rotated data outputs
// RULE_12: eight-groups 2-9,10-17,18-25,26-33 to any system
// RULE_13: sixteen-groups 2-17,10-25,18-33 to any system
// RULE_14: parity rebuilds any single lost group track
// RULE_15: parity bit is XOR across group per bit
// RULE_16: first field bit is sample at time code
// RULE_17: last field bit is sample before next code
`ifndef TBR_MAP_VH
`define TBR_MAP_VH

// register byte offsets
`define TBR_ADDR_CTRL 12'h000
`define TBR_ADDR_PAR 12'h004
`define TBR_ADDR_STAT 12'h008
`define TBR_ADDR_FIELD 12'h00C

// control register fields
`define TBR_CTRL_EN 0
`define TBR_CTRL_RESTART 1
`define TBR_CNT_LSB 8
`define TBR_CNT_MSB 13
`define TBR_RATE_LSB 16
`define TBR_RATE_MSB 19
`define TBR_CTRL_MASK 32'h000F_3F01
`define TBR_CTRL_RST 32'h0000_0000

// parity routing: one nibble per system output
`define TBR_PAR_MASK 32'h0000_FFFF
`define TBR_PAR_RST 32'h0000_0000
`define TBR_PAR_EN_BIT 3

// status fields
`define TBR_STAT_STEP_LSB 0
`define TBR_STAT_MODE_LSB 4
`define TBR_STAT_FRM_LSB 16

// rotation modes
`define TBR_MODE_OFF 2'h0
`define TBR_MODE_EIGHT 2'h1
`define TBR_MODE_SIXTEEN 2'h2

// parity group selects, 0..3 eight-wide, 4..6 sixteen-wide
`define TBR_GRP_SIXTEEN_BASE 3'h4

// write rate thresholds in Mbit/s per track
`define TBR_RATE_SLOW_MAX 4'h2
`define TBR_RATE_FAST_MIN 4'h4

// track layout
`define TBR_NUM_TRACKS 36
`define TBR_NUM_DATA 32
`define TBR_DATA_BASE 2
`define TBR_SYS_HI 34

`endif

// ==== design/tbr_xpar.v ====
`timescale 1ns/1ns
`include "tbr_map.vh"

// cross-track parity of one selected group of rotated data outputs
module tbr_xpar (
  input wire [31:0] data,
  input wire [2:0] grp_sel,
  output reg par
);

  reg [15:0] span;
  reg [4:0] base;

  always @* begin
    span = 16'h0000;
    base = 5'h00;
    if (grp_sel < `TBR_GRP_SIXTEEN_BASE) begin
      // groups 2-9, 10-17, 18-25, 26-33
      base = {grp_sel[1:0], 3'h0}; // [RULE_12]
      span = {8'h00, data[base +: 8]};
    end else if (grp_sel != 3'h7) begin
      // groups 2-17, 10-25, 18-33
      base = {grp_sel[1:0], 3'h0}; // [RULE_13]
      span = data[base +: 16];
    end
    // xor of all group bits: any one lost track is the xor of the rest
    par = ^span; // [RULE_14] [RULE_15]
  end

endmodule // tbr_xpar

// ==== design/tbr_top.v ====
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "tbr_map.vh"

module tbr_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire bit_valid,
  input wire frame_mark,
  input wire even_sec_mark,
  input wire tc_mark,
  input wire field_active,
  input wire [35:0] src_bits,
  output reg [35:0] trk_bits,
  output reg trk_valid,
  output reg field_first,
  output reg [3:0] roll_step
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // rotation mode from track count and per-track write rate
  function [1:0] mode_of;
    input [5:0] cnt;
    input [3:0] rate;
    begin
      mode_of = `TBR_MODE_OFF;
      if (cnt == 6'h00 || cnt[2:0] != 3'h0) begin
        mode_of = `TBR_MODE_OFF; // [RULE_05]
      end else if (cnt[3] == 1'b1) begin
        mode_of = `TBR_MODE_EIGHT; // [RULE_06]
      end else if (rate <= `TBR_RATE_SLOW_MAX) begin
        mode_of = `TBR_MODE_EIGHT; // [RULE_06]
      end else if (rate >= `TBR_RATE_FAST_MIN) begin
        mode_of = `TBR_MODE_SIXTEEN; // [RULE_08]
      end
      // rates strictly between the two thresholds leave rotation off
    end
  endfunction

  // source data index feeding data output j at step s.
  // index layout: bit0 track parity, bits 3:1 slot within the
  // eight same-parity tracks of a half, bit4 the half (2-17/18-33)
  function [4:0] src_idx;
    input [4:0] j;
    input [3:0] s;
    input sixteen;
    reg [2:0] slot;
    reg half;
    begin
      // stream in slot i lands in slot i+step: invert by subtracting
      slot = j[3:1] - s[2:0]; // [RULE_07] [RULE_09]
      // steps 8-15 of the long sequence swap halves
      half = j[4] ^ (sixteen & s[3]); // [RULE_09] [RULE_10]
      src_idx = {half, slot, j[0]}; // [RULE_10]
    end
  endfunction

  // status word packing; unused bits read zero
  function [31:0] stat_word;
    input [15:0] frm;
    input [1:0] md;
    input [3:0] stp;
    begin
      stat_word = 32'h0000_0000;
      stat_word[`TBR_STAT_FRM_LSB +: 16] = frm;
      stat_word[`TBR_STAT_MODE_LSB +: 2] = md;
      stat_word[`TBR_STAT_STEP_LSB +: 4] = stp;
    end
  endfunction

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] par_q;
  reg restart_q;
  wire wr_en;
  wire rd_en;
  wire addr_ok;

  // zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == `TBR_ADDR_CTRL) ||
                   (paddr == `TBR_ADDR_PAR) ||
                   (paddr == `TBR_ADDR_STAT) ||
                   (paddr == `TBR_ADDR_FIELD);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TBR_CTRL_RST;
      par_q <= `TBR_PAR_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (wr_en && paddr == `TBR_ADDR_CTRL) begin
        ctrl_q <= pwdata & `TBR_CTRL_MASK;
        restart_q <= pwdata[`TBR_CTRL_RESTART];
      end
      if (wr_en && paddr == `TBR_ADDR_PAR) begin
        par_q <= pwdata & `TBR_PAR_MASK;
      end
    end
  end

  wire [5:0] trk_cnt;
  wire [3:0] wr_rate;
  wire roll_en;
  wire [1:0] mode;
  wire sixteen;

  assign trk_cnt = ctrl_q[`TBR_CNT_MSB:`TBR_CNT_LSB];
  assign wr_rate = ctrl_q[`TBR_RATE_MSB:`TBR_RATE_LSB];
  assign roll_en = ctrl_q[`TBR_CTRL_EN];
  assign mode = roll_en ? mode_of(trk_cnt, wr_rate) : `TBR_MODE_OFF;
  assign sixteen = (mode == `TBR_MODE_SIXTEEN);

  // ---------------------------------------------------------------
  // step counter
  // ---------------------------------------------------------------
  reg [3:0] step_q;
  reg [3:0] step_d;
  reg [15:0] frm_cnt_q;

  always @* begin
    step_d = step_q;
    if (even_sec_mark || restart_q) begin
      // even-second restart wins over a frame in the same cycle
      step_d = 4'h0; // [RULE_04]
    end else if (frame_mark) begin
      if (sixteen) begin
        step_d = step_q + 4'h1; // [RULE_04]
      end else begin
        step_d = {1'b0, step_q[2:0] + 3'h1}; // [RULE_04]
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 4'h0;
      frm_cnt_q <= 16'h0000;
    end else begin
      step_q <= step_d;
      if (even_sec_mark || restart_q) begin
        frm_cnt_q <= 16'h0000;
      end else if (frame_mark) begin
        frm_cnt_q <= frm_cnt_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // track rotation
  // ---------------------------------------------------------------
  wire [31:0] data_in;
  reg [31:0] data_rot;
  integer k;

  assign data_in = src_bits[`TBR_SYS_HI-1:`TBR_DATA_BASE]; // [RULE_01]

  always @* begin
    data_rot = data_in;
    for (k = 0; k < `TBR_NUM_DATA; k = k + 1) begin
      if (mode != `TBR_MODE_OFF) begin
        // both modes work on groups of eight or sixteen tracks
        data_rot[k] = data_in[src_idx(k[4:0], step_q, sixteen)]; // [RULE_03]
      end
    end
  end

  // ---------------------------------------------------------------
  // cross-track parity on the rotated streams
  // ---------------------------------------------------------------
  wire [3:0] par_bit;
  wire [3:0] sys_in;
  reg [3:0] sys_out;
  integer n;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_par
      tbr_xpar u_xpar (
        .data(data_rot),
        .grp_sel(par_q[4*g +: 3]),
        .par(par_bit[g])
      ); // [RULE_11]
    end
  endgenerate

  // system streams stay on their own outputs unless parity replaces them
  assign sys_in = {src_bits[`TBR_NUM_TRACKS-1:`TBR_SYS_HI], src_bits[1:0]};

  always @* begin
    sys_out = sys_in; // [RULE_02]
    for (n = 0; n < 4; n = n + 1) begin
      if (par_q[4*n + `TBR_PAR_EN_BIT]) begin
        sys_out[n] = par_bit[n]; // [RULE_11] [RULE_12] [RULE_13]
      end
    end
  end

  // ---------------------------------------------------------------
  // output stage and field alignment
  // ---------------------------------------------------------------
  reg tc_pend_q;
  reg [15:0] fld_bits_q;
  reg [15:0] fld_last_q;
  reg fld_run_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trk_bits <= 36'h0_0000_0000;
      trk_valid <= 1'b0;
      roll_step <= 4'h0;
    end else begin
      trk_valid <= bit_valid;
      roll_step <= step_q;
      if (bit_valid) begin
        // samples pass in arrival order: overhead takes no sample slot
        trk_bits <= {sys_out[3:2], data_rot, sys_out[1:0]}; // [RULE_17]
      end
    end
  end

  // a time-code mark tags the sample of that instant as the first of
  // the next field; the pending flag covers marks seen before the field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_pend_q <= 1'b0;
      field_first <= 1'b0;
      fld_bits_q <= 16'h0000;
      fld_last_q <= 16'h0000;
      fld_run_q <= 1'b0;
    end else begin
      field_first <= 1'b0;
      if (bit_valid && field_active && (tc_mark || tc_pend_q)) begin
        field_first <= 1'b1; // [RULE_16]
        tc_pend_q <= 1'b0;
        fld_run_q <= 1'b1;
        fld_bits_q <= 16'h0001;
        if (fld_run_q) begin
          // bits of the field just closed, ending on the sample before this mark
          fld_last_q <= fld_bits_q; // [RULE_17]
        end
      end else begin
        if (tc_mark) begin
          tc_pend_q <= 1'b1; // [RULE_16]
        end
        if (bit_valid && field_active && fld_run_q) begin
          fld_bits_q <= fld_bits_q + 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // APB read and error answer
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= ~addr_ok;
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          case (paddr)
            `TBR_ADDR_CTRL: begin
              prdata <= ctrl_q;
            end
            `TBR_ADDR_PAR: begin
              prdata <= par_q;
            end
            `TBR_ADDR_STAT: begin
              prdata <= stat_word(frm_cnt_q, mode, step_q); // [RULE_04]
            end
            `TBR_ADDR_FIELD: begin
              prdata <= {16'h0000, fld_last_q};
            end
            default: begin
              prdata <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

endmodule // tbr_top

// ==== dv/tbr_checker.sv ====
`timescale 1ns/1ns
module tbr_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire bit_valid,
  input wire frame_mark,
  input wire even_sec_mark,
  input wire tc_mark,
  input wire field_active,
  input wire [35:0] src_bits,
  input wire [35:0] trk_bits,
  input wire trk_valid,
  input wire field_first,
  input wire [3:0] roll_step
);
  reg [15:0] par_q;
  wire wr = psel && penable && pwrite;
  wire calm = !frame_mark && !even_sec_mark && !wr;
  // shadow of parity routing, so head checks know which carry parity
  always @(posedge pclk or negedge presetn)
    if (!presetn) par_q <= 16'h0000;
    else if (wr && paddr == 12'h004) par_q <= pwdata[15:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_VALID: assert property (bit_valid |=> trk_valid)
    else $error("bit lost");
  AST_SYS_LO: assert property (trk_valid && !par_q[7] |->
    trk_bits[1] == $past(src_bits[1])) else $error("head 1 moved");
  AST_SYS_HI: assert property (trk_valid && !par_q[11] |->
    trk_bits[34] == $past(src_bits[34])) else $error("head 34 moved");
  AST_HOLD: assert property (calm |=> ##1 $stable(roll_step))
    else $error("step moved");
  AST_INC: assert property (frame_mark && !even_sec_mark && !wr
    |=> ##1 roll_step[2:0] == $past(roll_step[2:0]) + 3'h1)
    else $error("step stuck");
  AST_ZERO: assert property (even_sec_mark |=>
    ##1 roll_step == 4'h0) else $error("no restart");
  AST_PAR8: assert property (trk_valid && par_q[3:0] == 4'h8 |->
    trk_bits[0] == ^trk_bits[9:2]) else $error("parity 2-9");
  AST_PAR16: assert property (trk_valid && par_q[15:12] == 4'hE |->
    trk_bits[35] == ^trk_bits[33:18]) else $error("parity 18-33");
  AST_FIRST: assert property (tc_mark && bit_valid && field_active
    |=> field_first && trk_valid) else $error("first bit unmarked");
  C_EVEN: cover property (even_sec_mark);
  C_PAR: cover property (trk_valid && par_q[3]);
  C_FIRST: cover property (field_first);
endmodule // tbr_checker

// ==== dv/tbr_heads.sv ====
`timescale 1ns/1ns
// write heads: each keeps the last bit put on it
module tbr_heads (
  input wire pclk,
  input wire [35:0] trk_bits,
  input wire trk_valid,
  input wire field_first,
  output reg [35:0] head_q,
  output reg first_q
);
  // no reset: a head holds nothing until its first bit time
  always @(posedge pclk) begin
    if (trk_valid) begin
      head_q <= trk_bits;
      first_q <= field_first;
    end
  end
endmodule // tbr_heads

// ==== dv/test_tape_track_barrel_roll.sv ====
`timescale 1ns/1ns
`include "tbr_map.vh"
module test_tape_track_barrel_roll;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, bit_valid = 1'b0, frame_mark = 1'b0, tc_mark = 1'b0;
  reg even_sec_mark = 1'b0, field_active = 1'b0, rerr;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000, rdat;
  reg [35:0] src_bits = 36'h0_0000_0000, v, e;
  reg [3:0] s;
  wire [31:0] prdata;
  wire pready, pslverr, trk_valid, field_first, first_q;
  wire [35:0] trk_bits, head_q;
  wire [3:0] roll_step;
  integer bad_count = 0, checks = 0, cyc = 0, i, n, t, o;
  // count /8 only, /16 slow, /16 fast, not /8, /16 at 3 Mbit/s
  reg [5:0] cn [0:4] = '{6'h18, 6'h20, 6'h20, 6'h14, 6'h20};
  reg [3:0] rt [0:4] = '{4'h8, 4'h2, 4'h4, 4'h8, 4'h3};
  reg [1:0] md [0:4] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h0};
  reg [15:0] pv [0:4] = '{16'hB098, 16'hEDCA, 16'hCE0F, 16'h0000, 16'h8D00};
  tbr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_valid(bit_valid), .frame_mark(frame_mark),
    .even_sec_mark(even_sec_mark), .tc_mark(tc_mark),
    .field_active(field_active), .src_bits(src_bits), .trk_bits(trk_bits),
    .trk_valid(trk_valid), .field_first(field_first), .roll_step(roll_step));
  tbr_heads heads (.pclk(pclk), .trk_bits(trk_bits), .trk_valid(trk_valid),
    .field_first(field_first), .head_q(head_q), .first_q(first_q));
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc > 40000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [35:0] got, input [35:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        bad_count++;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task send(input [35:0] x, input tc);
    begin
      bit_valid <= 1'b1;
      src_bits <= x;
      tc_mark <= tc;
      @(posedge pclk);
      bit_valid <= 1'b0;
      tc_mark <= 1'b0;
      @(posedge pclk);
      @(posedge pclk);
    end
  endtask
  task mark(input f, input z);
    begin
      frame_mark <= f;
      even_sec_mark <= z;
      @(posedge pclk);
      frame_mark <= 1'b0;
      even_sec_mark <= 1'b0;
      @(posedge pclk);
    end
  endtask
  function [5:0] dest(input [5:0] h, input [1:0] m, input [3:0] k);
    reg [4:0] d;
    begin
      d = h[4:0] - 5'h02;
      if (m != 2'h0) d[3:1] = d[3:1] + k[2:0];
      if (m == 2'h2 && k[3]) d[4] = ~d[4];
      dest = {1'b0, d} + 6'h02;
    end
  endfunction
  function par(input [35:0] x, input [2:0] g);
    integer k;
    begin
      par = 1'b0;
      for (k = 0; k < (g[2] ? 16 : 8); k++)
        if (g != 3'h7) par = par ^ x[(g[2] ? 8 * g - 30 : 8 * g + 2) + k];
    end
  endfunction
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TBR_ADDR_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, `TBR_ADDR_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, `TBR_ADDR_CTRL, 32'h0000_0000);
    chk(rdat, 32'h000F_3F01);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({rerr, rdat}, 36'h1_0000_0000);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `TBR_ADDR_CTRL, {12'h000, rt[i], 2'h0, cn[i], 8'h01});
      apb(1'b1, `TBR_ADDR_PAR, {16'h0000, pv[i]});
      mark(1'b0, 1'b1);
      s = 4'h0;
      apb(1'b0, `TBR_ADDR_STAT, 32'h0000_0000);
      chk(rdat[5:0], {md[i], 4'h0});
      for (n = 0; n < 17; n++) begin
        // one-hot walk: each head's source is seen alone
        for (t = 0; t < 36; t++) begin
          v = 36'h0_0000_0001 << t;
          send(v, 1'b0);
          e = v & 36'hC_0000_0003;
          for (o = 2; o < 34; o++) e[dest(o, md[i], s)] = v[o];
          for (o = 0; o < 4; o++)
            if (pv[i][4 * o + 3])
              e[o < 2 ? o : o + 32] = par(e, pv[i][4 * o +: 3]);
          chk(head_q, e);
          if (t == 0) chk(roll_step, s);
        end
        mark(1'b1, 1'b0);
        s = md[i] == 2'h2 ? s + 4'h1 : {1'b0, s[2:0] + 3'h1};
      end
      apb(1'b0, `TBR_ADDR_STAT, 32'h0000_0000);
      chk(rdat, {16'h0011, 10'h000, md[i], s});
    end
    field_active <= 1'b1;
    // the mark on the eleventh bit closes the ten-bit field
    for (t = 0; t < 11; t++) begin
      send(36'h0_0000_0001 << t, t == 0 || t == 10);
      chk(first_q, t == 0 || t == 10);
    end
    field_active <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, `TBR_ADDR_FIELD, 32'h0000_0000);
    chk(rdat, 32'h0000_000A);
    end_of_test;
  end
endmodule // test_tape_track_barrel_roll
bind tbr_top tbr_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .bit_valid(bit_valid), .frame_mark(frame_mark),
  .even_sec_mark(even_sec_mark), .tc_mark(tc_mark),
  .field_active(field_active), .src_bits(src_bits), .trk_bits(trk_bits),
  .trk_valid(trk_valid), .field_first(field_first), .roll_step(roll_step));
